// [rtl/afe_pkg.sv]
// Shared constants and carrier types of the sensor front-end control block
package afe_pkg;

	localparam int unsigned CLK_HZ         = 250_000_000;
	localparam int unsigned CHOP_HZ        = 12_000;
	localparam int unsigned CHOP_HALF      = CLK_HZ / (2 * CHOP_HZ);
	localparam int unsigned ACC_COUNT      = 16;
	localparam int unsigned PRESCALE_BASE  = 3;

	localparam logic [7:0] OFS_CHOP_GAIN   = 8'h00;
	localparam logic [7:0] OFS_AMP2_OFFSET = 8'h04;
	localparam logic [7:0] OFS_FE_ENABLE   = 8'h08;
	localparam logic [7:0] OFS_FILT_GAIN   = 8'h0C;
	localparam logic [7:0] OFS_FILT_STATUS = 8'h10;
	localparam logic [7:0] OFS_FILT_DIV    = 8'h14;
	localparam logic [7:0] OFS_CURRENT     = 8'h18;
	localparam logic [7:0] OFS_CONV_CTRL   = 8'h1C;
	localparam logic [7:0] OFS_RESULT_LO   = 8'h20;
	localparam logic [7:0] OFS_RESULT_HI   = 8'h24;
	localparam logic [7:0] OFS_IRQ_FLAGS   = 8'h28;

	localparam logic [7:0] REG_RESET       = 8'h00;

	localparam logic [7:0] MASK_CHOP_GAIN  = 8'hFF;
	localparam logic [7:0] MASK_FE_ENABLE  = 8'hDF;
	localparam logic [7:0] MASK_FILT_STAT  = 8'h3C;
	localparam logic [7:0] MASK_CURRENT    = 8'hEF;
	localparam logic [7:0] MASK_CONV_CTRL  = 8'h81;

	localparam int unsigned BIT_CHOP_EN    = 7;
	localparam int unsigned BIT_FE_EN      = 7;
	localparam int unsigned BIT_AMP2_GAIN  = 6;
	localparam int unsigned BIT_READY      = 6;
	localparam int unsigned BIT_AUTO_CONV  = 5;
	localparam int unsigned POS_PRESCALE   = 2;
	localparam int unsigned BIT_CUR_EN     = 7;
	localparam int unsigned BIT_BAT_EN     = 6;
	localparam int unsigned BIT_ACCUM      = 5;
	localparam int unsigned BIT_START      = 7;
	localparam int unsigned BIT_BUSY       = 6;
	localparam int unsigned BIT_CONV_IE    = 0;
	localparam int unsigned BIT_FILT_IRQ   = 0;
	localparam int unsigned BIT_CONV_IRQ   = 1;

	localparam logic [6:0] STAGE2_BASE     = 7'h20;
	localparam logic [8:0] FILT_GAIN_BASE  = 9'h038;
	localparam logic [9:0] CUR_REF_BASE_MV = 10'h0C8;
	localparam logic [9:0] CUR_REF_STEP_MV = 10'h032;

	typedef enum logic [0:0]
	{
		CONV_IDLE = 1'b0,
		CONV_RUN  = 1'b1
	} conv_state_t;

	typedef struct packed
	{
		logic       chopper_clk;
		logic       amp_power_down;
		logic [6:0] stage2_gain_x32;
		logic [7:0] second_amp_offset_sel;
		logic       second_amp_gain_x2;
		logic [4:0] filter_amp_offset_sel;
		logic [3:0] lowpass_cutoff_hot;
		logic [8:0] filter_amp_gain;
		logic       filter_clk;
		logic       current_source_pd;
		logic [9:0] current_ref_mv;
		logic       battery_detect_enable;
	} afe_ctrl_t;

	typedef struct packed
	{
		logic start;
		logic use_filter;
		logic accumulate;
	} conv_cmd_t;

endpackage : afe_pkg

// [rtl/filter_clock_divider.sv]
// Prescaler and divider that make the switched-capacitor filter clock
`timescale 1ns/1ns
module filter_clock_divider
#(
	parameter int unsigned PRE_W = 3,
	parameter int unsigned DIV_W = 8
)
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             enable,
	input  wire logic [PRE_W-1:0] prescale_sel,
	input  wire logic [DIV_W-1:0] div_val,
	output logic                  filter_clk
);

	localparam int unsigned CNT_W = DIV_W + PRE_W + 8;

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] period;

	initial
	begin
		if (PRE_W != 3 || DIV_W < 1 || DIV_W > 16)
			$error("filter_clock_divider: unsupported widths");
	end

	// Period in system clocks: (div + 1) * 8 * 2^sel
	// Shift amount widened so sel + 3 cannot wrap for the top codes
	assign period = CNT_W'(({{(CNT_W-DIV_W){1'b0}}, div_val} + 1'b1)
		<< ({2'b00, prescale_sel} + 5'(afe_pkg::PRESCALE_BASE)));

	// Reload at terminal count, one filter period per division
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_q <= '0;
		else if (!enable || cnt_q >= period - 1'b1)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + 1'b1;
	end

	// High for the first half of each period
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			filter_clk <= 1'b0;
		else
			filter_clk <= enable && (cnt_q < (period >> 1));
	end

endmodule : filter_clock_divider

// [rtl/sensor_frontend_control.sv]
// Register file, clocks and conversion sequencing of the sensor front end
`timescale 1ns/1ns
module sensor_frontend_control
#(
	parameter int unsigned ADDR_W     = 8,
	parameter int unsigned CHOP_HALF  = afe_pkg::CHOP_HALF,
	parameter int unsigned RESULT_W   = 12
)
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              filter_output_ready,
	input  wire logic              conv_done,
	input  wire logic [RESULT_W-1:0] conv_data,
	output afe_pkg::afe_ctrl_t     afe_ctrl,
	output afe_pkg::conv_cmd_t     conv_cmd,
	output logic                   converter_busy,
	output logic                   filter_irq,
	output logic                   conv_irq
);

	localparam int unsigned ACC_W = 16;
	localparam int unsigned CHOP_W = $clog2(CHOP_HALF + 1);

	initial
	begin
		if (ADDR_W < 6 || CHOP_HALF < 1 || RESULT_W != 12)
			$error("sensor_frontend_control: unsupported parameters");
	end

	logic [7:0] chop_gain_q;
	logic [7:0] amp2_offset_q;
	logic [7:0] fe_enable_q;
	logic [7:0] filt_gain_q;
	logic [7:0] filt_status_q;
	logic [7:0] filt_div_q;
	logic [7:0] current_q;
	logic [7:0] conv_ctrl_q;
	logic [1:0] irq_flags_q;
	logic [ACC_W-1:0] result_q;
	logic [ACC_W-1:0] acc_q;
	logic [3:0]  acc_cnt_q;
	logic [31:0] rdata_d;
	logic        unmapped_d;
	logic        wr_en;
	logic        rd_setup;
	logic [1:0]  ready_sync_q;
	logic        ready_prev_q;
	logic        ready_rise;
	logic        sw_trig;
	logic        auto_trig;
	logic        new_req;
	logic        last_conv;
	logic        conv_finish;
	logic [CHOP_W-1:0] chop_cnt_q;
	logic        chop_clk_q;
	logic        filter_clk_w;
	afe_pkg::conv_state_t state_q;

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [7:0] ofs);
		hit = (a == ADDR_W'(ofs));
	endfunction : hit

	// APB: one wait state, writes land at the edge where pready is high
	assign wr_en    = psel && penable && pwrite && pready;
	assign rd_setup = psel && penable && !pready;

	// Unimplemented bits are masked away on both sides, except in the chopper gain register
	always_comb
	begin
		rdata_d    = '0;
		unmapped_d = 1'b0;
		case (1'b1)
			hit(paddr, afe_pkg::OFS_CHOP_GAIN):
				rdata_d[7:0] = chop_gain_q;
			hit(paddr, afe_pkg::OFS_AMP2_OFFSET):
				rdata_d[7:0] = amp2_offset_q;
			hit(paddr, afe_pkg::OFS_FE_ENABLE):
				rdata_d[7:0] = fe_enable_q & afe_pkg::MASK_FE_ENABLE;
			hit(paddr, afe_pkg::OFS_FILT_GAIN):
				rdata_d[7:0] = filt_gain_q;
			hit(paddr, afe_pkg::OFS_FILT_STATUS):
			begin
				rdata_d[7:0] = filt_status_q & afe_pkg::MASK_FILT_STAT;
				rdata_d[afe_pkg::BIT_READY] = ready_prev_q;
			end
			hit(paddr, afe_pkg::OFS_FILT_DIV):
				rdata_d[7:0] = filt_div_q;
			hit(paddr, afe_pkg::OFS_CURRENT):
				rdata_d[7:0] = current_q & afe_pkg::MASK_CURRENT;
			hit(paddr, afe_pkg::OFS_CONV_CTRL):
			begin
				rdata_d[7:0] = conv_ctrl_q & afe_pkg::MASK_CONV_CTRL;
				rdata_d[afe_pkg::BIT_BUSY] = converter_busy;
			end
			hit(paddr, afe_pkg::OFS_RESULT_LO):
				rdata_d[7:0] = result_q[7:0];
			hit(paddr, afe_pkg::OFS_RESULT_HI):
				rdata_d[7:0] = result_q[15:8];
			hit(paddr, afe_pkg::OFS_IRQ_FLAGS):
				rdata_d[1:0] = irq_flags_q;
			default:
				unmapped_d = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= rd_setup;
			prdata  <= rd_setup ? rdata_d : '0;
			pslverr <= rd_setup && unmapped_d;
		end
	end

	// Reserved gain bits are stored as written; software keeps them 0
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			chop_gain_q   <= afe_pkg::REG_RESET;
			amp2_offset_q <= afe_pkg::REG_RESET;
			fe_enable_q   <= afe_pkg::REG_RESET;
			filt_gain_q   <= afe_pkg::REG_RESET;
			filt_status_q <= afe_pkg::REG_RESET;
			filt_div_q    <= afe_pkg::REG_RESET;
			current_q     <= afe_pkg::REG_RESET;
			conv_ctrl_q   <= afe_pkg::REG_RESET;
		end
		else if (wr_en)
		begin
			if (hit(paddr, afe_pkg::OFS_CHOP_GAIN))
				chop_gain_q <= pwdata[7:0] & afe_pkg::MASK_CHOP_GAIN;
			if (hit(paddr, afe_pkg::OFS_AMP2_OFFSET))
				amp2_offset_q <= pwdata[7:0];
			if (hit(paddr, afe_pkg::OFS_FE_ENABLE))
				fe_enable_q <= pwdata[7:0] & afe_pkg::MASK_FE_ENABLE;
			if (hit(paddr, afe_pkg::OFS_FILT_GAIN))
				filt_gain_q <= pwdata[7:0];
			if (hit(paddr, afe_pkg::OFS_FILT_STATUS))
				filt_status_q <= pwdata[7:0] & afe_pkg::MASK_FILT_STAT;
			if (hit(paddr, afe_pkg::OFS_FILT_DIV))
				filt_div_q <= pwdata[7:0];
			if (hit(paddr, afe_pkg::OFS_CURRENT))
				current_q <= pwdata[7:0] & afe_pkg::MASK_CURRENT;
			if (hit(paddr, afe_pkg::OFS_CONV_CTRL))
				conv_ctrl_q <= pwdata[7:0] & afe_pkg::MASK_CONV_CTRL;
		end
	end

	// Ready comes from the analog filter, so it is synchronised first
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ready_sync_q <= 2'b00;
			ready_prev_q <= 1'b0;
		end
		else
		begin
			ready_sync_q <= {ready_sync_q[0], filter_output_ready};
			ready_prev_q <= ready_sync_q[1];
		end
	end

	assign ready_rise = ready_sync_q[1] && !ready_prev_q;

	// Start fires on the write that takes the start bit from 1 back to 0
	assign sw_trig = wr_en && hit(paddr, afe_pkg::OFS_CONV_CTRL)
		&& conv_ctrl_q[afe_pkg::BIT_START]
		&& !pwdata[afe_pkg::BIT_START];
	assign auto_trig = ready_rise
		&& filt_status_q[afe_pkg::BIT_AUTO_CONV];
	assign new_req   = sw_trig || auto_trig;
	assign last_conv = !current_q[afe_pkg::BIT_ACCUM]
		|| (acc_cnt_q == 4'(afe_pkg::ACC_COUNT - 1));
	// A new request aborts the running one rather than queueing behind it
	assign conv_finish = (state_q == afe_pkg::CONV_RUN) && conv_done
		&& last_conv && !new_req;

	// Conversion sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q        <= afe_pkg::CONV_IDLE;
			converter_busy <= 1'b0;
			conv_cmd       <= '0;
			acc_q          <= '0;
			acc_cnt_q      <= '0;
			result_q       <= '0;
		end
		else
		begin
			conv_cmd.start      <= 1'b0;
			conv_cmd.use_filter <= filt_status_q[afe_pkg::BIT_AUTO_CONV];
			conv_cmd.accumulate <= current_q[afe_pkg::BIT_ACCUM];
			if (new_req)
			begin
				state_q        <= afe_pkg::CONV_RUN;
				converter_busy <= 1'b1;
				conv_cmd.start <= 1'b1;
				acc_q          <= '0;
				acc_cnt_q      <= '0;
			end
			else
			begin
				case (state_q)
					afe_pkg::CONV_IDLE:
						converter_busy <= 1'b0;
					afe_pkg::CONV_RUN:
					begin
						if (conv_done && !current_q[afe_pkg::BIT_ACCUM])
						begin
							result_q       <= ACC_W'(conv_data);
							state_q        <= afe_pkg::CONV_IDLE;
							converter_busy <= 1'b0;
						end
						else if (conv_done && last_conv)
						begin
							result_q       <= acc_q + ACC_W'(conv_data);
							state_q        <= afe_pkg::CONV_IDLE;
							converter_busy <= 1'b0;
						end
						else if (conv_done)
						begin
							acc_q          <= acc_q + ACC_W'(conv_data);
							acc_cnt_q      <= acc_cnt_q + 4'h1;
							conv_cmd.start <= 1'b1;
						end
					end
					default:
						state_q <= afe_pkg::CONV_IDLE;
				endcase
			end
		end
	end

	// Sticky flags, write one to clear; a new event wins over the clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_flags_q <= 2'b00;
		else
		begin
			if (wr_en && hit(paddr, afe_pkg::OFS_IRQ_FLAGS))
				irq_flags_q <= irq_flags_q & ~pwdata[1:0];
			if (ready_rise)
				irq_flags_q[afe_pkg::BIT_FILT_IRQ] <= 1'b1;
			if (conv_finish)
				irq_flags_q[afe_pkg::BIT_CONV_IRQ] <= 1'b1;
		end
	end

	// Interrupt requests are one-cycle pulses
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			filter_irq <= 1'b0;
			conv_irq   <= 1'b0;
		end
		else
		begin
			filter_irq <= ready_rise;
			conv_irq   <= conv_finish
				&& conv_ctrl_q[afe_pkg::BIT_CONV_IE];
		end
	end

	// Chopper clock: half period counted in system clocks
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			chop_cnt_q <= '0;
			chop_clk_q <= 1'b0;
		end
		else if (!chop_gain_q[afe_pkg::BIT_CHOP_EN])
		begin
			chop_cnt_q <= '0;
			chop_clk_q <= 1'b0;
		end
		else if (chop_cnt_q == CHOP_W'(CHOP_HALF - 1))
		begin
			chop_cnt_q <= '0;
			chop_clk_q <= !chop_clk_q;
		end
		else
			chop_cnt_q <= chop_cnt_q + 1'b1;
	end

	// Filter clock stops while the front end is powered down
	filter_clock_divider
	#(
		.PRE_W (3),
		.DIV_W (8)
	)
	u_filter_clock_divider
	(
		.pclk         (pclk),
		.presetn      (presetn),
		.enable       (fe_enable_q[afe_pkg::BIT_FE_EN]),
		.prescale_sel (filt_status_q[afe_pkg::POS_PRESCALE +: 3]),
		.div_val      (filt_div_q),
		.filter_clk   (filter_clk_w)
	);

	function automatic logic [3:0] cutoff_hot(input logic [1:0] sel);
		cutoff_hot = 4'h1 << sel;
	endfunction : cutoff_hot

	// Analog controls, decoded and registered so each is glitch free
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			afe_ctrl <= '0;
		else
		begin
			afe_ctrl.chopper_clk <= chop_clk_q;
			afe_ctrl.amp_power_down <=
				!fe_enable_q[afe_pkg::BIT_FE_EN];
			afe_ctrl.stage2_gain_x32 <= afe_pkg::STAGE2_BASE
				+ 7'(chop_gain_q[4:0]) * 7'h03;
			afe_ctrl.second_amp_offset_sel <= amp2_offset_q;
			afe_ctrl.second_amp_gain_x2 <=
				!fe_enable_q[afe_pkg::BIT_AMP2_GAIN];
			afe_ctrl.filter_amp_offset_sel <= fe_enable_q[4:0];
			afe_ctrl.lowpass_cutoff_hot <=
				cutoff_hot(filt_gain_q[7:6]);
			afe_ctrl.filter_amp_gain <= afe_pkg::FILT_GAIN_BASE
				+ {1'b0, filt_gain_q[5:0], 2'b00};
			afe_ctrl.filter_clk <= filter_clk_w;
			afe_ctrl.current_source_pd <=
				!current_q[afe_pkg::BIT_CUR_EN];
			afe_ctrl.current_ref_mv <= afe_pkg::CUR_REF_BASE_MV
				+ 10'(current_q[3:0]) * afe_pkg::CUR_REF_STEP_MV;
			afe_ctrl.battery_detect_enable <=
				current_q[afe_pkg::BIT_BAT_EN];
		end
	end

endmodule : sensor_frontend_control

// [testbench/sfc_chk.sv]
// Port assertions for the sensor front-end control block
`timescale 1ns/1ns
module sfc_chk
(
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic               filter_output_ready,
	input wire logic               conv_done,
	input wire afe_pkg::afe_ctrl_t afe_ctrl,
	input wire afe_pkg::conv_cmd_t conv_cmd,
	input wire logic               converter_busy,
	input wire logic               filter_irq,
	input wire logic               conv_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_pulse: assert property (pready |=> !pready) // Bus answer
		else $error("pready held longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("pslverr without pready or with data");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside the answer cycle");
	a_irq_pulse: assert property (filter_irq |=> !filter_irq)
		else $error("filter request longer than one cycle");
	a_ready_cause: assert property (
		filter_irq |-> $past(filter_output_ready, 3))
		else $error("filter request without a ready input");
	a_gain_form: assert property (
		afe_ctrl.filter_amp_gain[1:0] == 2'h0)
		else $error("filter gain not in steps of four");
	a_pd_filter_clk: assert property (
		afe_ctrl.amp_power_down [*3] |-> !afe_ctrl.filter_clk)
		else $error("filter clock runs while powered down");
	a_start_busy: assert property (conv_cmd.start |-> converter_busy)
		else $error("start issued without busy");
	a_single_end: assert property (
		conv_done && !conv_cmd.accumulate |=> !converter_busy)
		else $error("busy stays after a single conversion");
	a_irq_end: assert property (
		conv_irq |-> !converter_busy && $past(converter_busy))
		else $error("converter request not at end of run");
endmodule : sfc_chk

bind sensor_frontend_control sfc_chk u_chk
(
	.pclk(pclk), .presetn(presetn), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .filter_output_ready(filter_output_ready),
	.conv_done(conv_done), .afe_ctrl(afe_ctrl), .conv_cmd(conv_cmd),
	.converter_busy(converter_busy), .filter_irq(filter_irq),
	.conv_irq(conv_irq)
);

// [testbench/conv_model.sv]
// Behavioural model of the converter core behind the block
`timescale 1ns/1ns
module conv_model
(
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire afe_pkg::conv_cmd_t conv_cmd,
	input  wire logic [3:0]         lat,
	output logic                    conv_done,
	output logic [11:0]             conv_data
);
	logic [3:0]  cnt_q;
	logic        run_q;
	logic [11:0] val_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q     <= 4'h0;
			run_q     <= 1'b0;
			val_q     <= 12'h123;
			conv_done <= 1'b0;
			conv_data <= 12'h000;
		end
		else
		begin
			conv_done <= 1'b0;
			// Toggled outside a result so a stale value never matches
			conv_data <= ~conv_data;
			if (conv_cmd.start)
			begin
				run_q <= 1'b1;
				cnt_q <= lat;
			end
			else if (run_q && cnt_q == 4'h0)
			begin
				run_q     <= 1'b0;
				conv_done <= 1'b1;
				conv_data <= val_q;
				val_q     <= val_q + 12'h111;
			end
			else if (run_q)
				cnt_q <= cnt_q - 4'h1;
		end
	end
endmodule : conv_model

// [testbench/sensor_frontend_control_tb.sv]
// Self-checking bench for the sensor front-end control block
`timescale 1ns/1ns
module sensor_frontend_control_tb;
	typedef struct packed
	{
		logic       rd;
		logic       err;
		logic [7:0] dat;
	} exp_t;

	localparam int CHOP = 4;
	logic               pclk;
	logic               presetn;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [7:0]         paddr;
	logic [31:0]        pwdata;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic               filter_output_ready;
	logic               conv_done;
	logic [11:0]        conv_data;
	afe_pkg::afe_ctrl_t afe_ctrl;
	afe_pkg::conv_cmd_t conv_cmd;
	logic               converter_busy;
	logic               filter_irq;
	logic               conv_irq;
	logic [3:0]         lat;
	exp_t               x;
	exp_t               exp_q[$];
	int                 bad_count;
	int                 num_checks;
	int                 ndone;
	int                 nirq;
	int                 n;
	int                 i;
	logic [7:0]         r[7];
	logic [15:0]        sum;
	logic [7:0]  msk[7] = '{8'hFF, 8'hFF, 8'hDF, 8'hFF, 8'h3C, 8'hFF, 8'hEF};
	logic [2:0]  fsel[4] = '{3'h0, 3'h0, 3'h3, 3'h7};
	logic [7:0]  fdiv[4] = '{8'h00, 8'hFF, 8'h01, 8'h00};

	sensor_frontend_control #(.CHOP_HALF(CHOP)) u_dut
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.filter_output_ready(filter_output_ready), .conv_done(conv_done),
		.conv_data(conv_data), .afe_ctrl(afe_ctrl), .conv_cmd(conv_cmd),
		.converter_busy(converter_busy), .filter_irq(filter_irq),
		.conv_irq(conv_irq)
	);
	conv_model u_conv
	(
		.pclk(pclk), .presetn(presetn), .conv_cmd(conv_cmd), .lat(lat),
		.conv_done(conv_done), .conv_data(conv_data)
	);

	initial pclk = 1'b0;
	always #2 pclk = ~pclk;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task final_report;
		$display("Checks made %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report

	// Expected answer is queued before the request goes out
	task apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] e);
		exp_q.push_back(exp_t'{!wr, a > 8'h28, e});
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		// No cycle count assumed: only the watchdog ends a hung wait
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// Skips one period so a divider still on old settings is not measured
	task meas(input logic f, output int t);
		int   k;
		logic p;
		logic s;
		k = 0;
		t = 0;
		p = 1'b1;
		while (k < 3 && t < 5000)
		begin
			@(posedge pclk);
			s = f ? afe_ctrl.filter_clk : afe_ctrl.chopper_clk;
			t++;
			if (s === 1'b1 && p === 1'b0)
			begin
				k++;
				if (k < 3)
					t = 0;
			end
			p = s;
		end
	endtask : meas

	function automatic logic [11:0] val(input int k);
		return 12'(32'h123 + k * 32'h111);
	endfunction : val

	always @(posedge pclk)
	begin
		if (conv_done === 1'b1)
			ndone++;
		if (conv_irq === 1'b1)
			nirq++;
		if (pready === 1'b1)
		begin
			x = (exp_q.size() > 0) ? exp_q.pop_front() : exp_t'{1'b1, 1'b1, 8'hEE};
			check(pslverr, x.err);
			if (x.rd)
				check(prdata, {24'h000000, x.dat});
		end
	end

	initial
	begin
		repeat (40000) @(posedge pclk);
		bad_count++;
		final_report();
	end

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		filter_output_ready = 1'b0;
		lat = 4'h0;
		n = $urandom(32'h50C0);
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (i = 0; i < 12; i++)
			apb(1'b0, 8'(4 * i), 8'h00, 8'h00);
		apb(1'b1, 8'h2C, 8'hFF, 8'h00);
		for (n = 0; n < 3; n++)
		begin
			for (i = 0; i < 7; i++)
			begin
				r[i] = 8'($urandom) & (i == 0 ? 8'h9F : 8'hFF);
				apb(1'b1, 8'(4 * i), r[i], 8'h00);
			end
			for (i = 0; i < 7; i++)
				apb(1'b0, 8'(4 * i), 8'h00, r[i] & msk[i]);
			check(afe_ctrl.stage2_gain_x32, 7'(32 + 3 * r[0][4:0]));
			check(afe_ctrl.second_amp_offset_sel, r[1]);
			check(afe_ctrl.amp_power_down, !r[2][7]);
			check(afe_ctrl.second_amp_gain_x2, !r[2][6]);
			check(afe_ctrl.filter_amp_offset_sel, r[2][4:0]);
			check(afe_ctrl.lowpass_cutoff_hot, 4'h1 << r[3][7:6]);
			check(afe_ctrl.filter_amp_gain, 9'(56 + 4 * r[3][5:0]));
			check(conv_cmd.use_filter, r[4][5]);
			check(afe_ctrl.current_source_pd, !r[6][7]);
			check(afe_ctrl.current_ref_mv, 10'(200 + 50 * r[6][3:0]));
			check(afe_ctrl.battery_detect_enable, r[6][6]);
			check(conv_cmd.accumulate, r[6][5]);
		end
		apb(1'b1, afe_pkg::OFS_CHOP_GAIN, 8'h80, 8'h00);
		meas(1'b0, n);
		check(n, 2 * CHOP);
		apb(1'b1, afe_pkg::OFS_CHOP_GAIN, 8'h00, 8'h00);
		repeat (2) @(posedge pclk);
		n = 0;
		repeat (40)
		begin
			@(posedge pclk);
			n += (afe_ctrl.chopper_clk !== 1'b0);
		end
		check(n, 0);
		apb(1'b1, afe_pkg::OFS_FE_ENABLE, 8'h80, 8'h00);
		// Random setup may have left accumulation on; auto test wants single
		apb(1'b1, afe_pkg::OFS_CURRENT, 8'h00, 8'h00);
		for (i = 0; i < 4; i++)
		begin
			apb(1'b1, afe_pkg::OFS_FILT_STATUS, {3'h0, fsel[i], 2'h0}, 8'h00);
			apb(1'b1, afe_pkg::OFS_FILT_DIV, fdiv[i], 8'h00);
			meas(1'b1, n);
			check(n, (fdiv[i] + 1) * (8 << fsel[i]));
		end
		for (i = 0; i < 2; i++)
		begin
			apb(1'b1, afe_pkg::OFS_FILT_STATUS, 8'(i << 5), 8'h00);
			filter_output_ready <= 1'b1;
			n = 0;
			do
			begin
				@(posedge pclk);
				n++;
			end
			while (filter_irq !== 1'b1 && n < 10);
			check(n < 10, 1'b1);
			check(conv_cmd.start, i[0]);
			check(conv_cmd.use_filter, i[0]);
			repeat (8) @(posedge pclk);
			apb(1'b0, afe_pkg::OFS_FILT_STATUS, 8'h00, 8'(8'h40 | i << 5));
			apb(1'b0, afe_pkg::OFS_IRQ_FLAGS, 8'h00, 8'(1 + 2 * i));
			apb(1'b1, afe_pkg::OFS_IRQ_FLAGS, 8'h03, 8'h00);
			apb(1'b0, afe_pkg::OFS_IRQ_FLAGS, 8'h00, 8'h00);
			filter_output_ready <= 1'b0;
		end
		sum = {4'h0, val(ndone - 1)};
		apb(1'b0, afe_pkg::OFS_RESULT_LO, 8'h00, sum[7:0]);
		apb(1'b0, afe_pkg::OFS_RESULT_HI, 8'h00, sum[15:8]);
		lat <= 4'h9;
		apb(1'b1, afe_pkg::OFS_CURRENT, 8'hA7, 8'h00);
		nirq = 0;
		for (i = 0; i < 2; i++)
		begin
			apb(1'b1, afe_pkg::OFS_CONV_CTRL, 8'h81, 8'h00);
			apb(1'b1, afe_pkg::OFS_CONV_CTRL, 8'h01, 8'h00);
			n = ndone + 5;
			repeat (100) if (ndone < n) @(posedge pclk);
		end
		n = 0;
		while (converter_busy !== 1'b0 && n < 2000)
		begin
			@(posedge pclk);
			n++;
		end
		@(posedge pclk);
		check(nirq, 1);
		sum = 16'h0000;
		for (i = ndone - 16; i < ndone; i++)
			sum += val(i);
		apb(1'b0, afe_pkg::OFS_RESULT_LO, 8'h00, sum[7:0]);
		apb(1'b0, afe_pkg::OFS_RESULT_HI, 8'h00, sum[15:8]);
		repeat (3) @(posedge pclk);
		check(exp_q.size(), 0);
		final_report();
	end
endmodule : sensor_frontend_control_tb
